// ===== rtl/lttv4_dev.sv
// controller end: parses commands, runs the transmitter test, answers events.
// assumes host and controller on one clock, synchronous active-low reset.
// Contract
// - opcode 0x08/0x007B starts transmitter test
// - accepted command starts periodic packet transmission
// - refused while receiver test runs
// - channel field legal 0x00 to 0x27
// - length field sets payload bytes
// - codes 0 and 3 pick PRBS9, PRBS15
// - other codes pick repeated byte patterns
// - PHY codes 1 to 4, rest reserved
// - host sends zero extension length, type
// - host sends pattern length one, antenna zero
// - extension length zero or 0x02..0x14
// - extension type codes 0..2 only
// - pattern length sizes antenna list
// - power requested, nearest, minimum or maximum
// - command complete event follows every command
// - status zero success, else error code
// - event framed 04 0E 04 credit opcode status, or 04 0E 06 with count after test end
// - event carries command credit octet
// - test end stops test, returns count
module lttv4_dev
    import lttv4_pkg::*;
#(
    parameter int PKT_INTERVAL = PKT_INTERVAL_CYC
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // host link
    lttv4_if.dev link,
    // radio side
    input wire logic rx_test_run,
    output logic rx_end_req,
    output logic tx_run,
    output logic [7:0] tx_chan,
    output logic [7:0] tx_phy,
    output logic [7:0] tx_power,
    output logic tx_pkt_start,
    output logic tx_bit,
    output logic tx_bit_valid
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001, S_OPL = 7'b0000010, S_OPH = 7'b0000100, S_PLEN = 7'b0001000,
        S_PARAM = 7'b0010000, S_EXEC = 7'b0100000, S_EVT = 7'b1000000
    } lttv4_state_t;

    lttv4_state_t state_r;
    logic cmd_ready_r, evt_valid_r;
    logic [7:0] evt_data_r, eidx_r, pidx_r, plen_r, status_r, pwr_r, len_r, pay_r;
    logic [15:0] op_r, pkt_cnt_r, end_cnt_r, bits_r;
    logic [7:0] param_r [0:7];
    logic run_r, end_op_r, strobe_r, bit_r, bit_valid_r, rx_end_r;
    logic [7:0] chan_r, phy_r, power_r;
    logic [31:0] ival_r;
    logic [2:0] phase_r;
    logic [8:0] prbs9_r;
    logic [14:0] prbs15_r;

    assign link.cmd_ready = cmd_ready_r;
    assign link.evt_valid = evt_valid_r;
    assign link.evt_data = evt_data_r;
    assign rx_end_req = rx_end_r;
    assign tx_run = run_r;
    assign tx_chan = chan_r;
    assign tx_phy = phy_r;
    assign tx_power = power_r;
    assign tx_pkt_start = strobe_r;
    assign tx_bit = bit_r;
    assign tx_bit_valid = bit_valid_r;

    // repeated byte pattern for a payload code
    function automatic logic [7:0] pat_byte(input logic [7:0] code);
        unique case (code)
            8'h01: pat_byte = PAT_F0;
            8'h02: pat_byte = PAT_AA;
            8'h04: pat_byte = PAT_FF;
            8'h06: pat_byte = PAT_0F;
            8'h07: pat_byte = PAT_55;
            default: pat_byte = PAT_00;
        endcase
    endfunction : pat_byte

    // handshakes
    wire take = ce && link.cmd_valid && cmd_ready_r;
    wire give = ce && evt_valid_r && link.evt_ready;
    wire last_param = (pidx_r == plen_r - 8'h01);

    // command decode and checks
    wire is_tx = (op_r == OP_TX_V4);
    wire is_end = (op_r == OP_TEST_END);
    wire [7:0] p_chan = param_r[IDX_CHAN[2:0]];
    wire [7:0] p_pay = param_r[IDX_PAY[2:0]];
    wire [7:0] p_phy = param_r[IDX_PHY[2:0]];
    wire [7:0] p_ctel = param_r[IDX_CTE_LEN[2:0]];
    wire [7:0] p_ctyp = param_r[IDX_CTE_TYPE[2:0]];
    wire [7:0] p_spl = param_r[IDX_SPL[2:0]];
    wire bad_chan = p_chan > CHAN_MAX;
    wire bad_pay = p_pay > PAYLOAD_MAX;
    wire bad_phy = (p_phy < PHY_1M) || (p_phy > PHY_CODED_S2);
    wire bad_ctel = (p_ctel != CTE_NONE) && ((p_ctel < CTE_LEN_MIN) || (p_ctel > CTE_LEN_MAX));
    wire bad_ctyp = p_ctyp > CTE_TYPE_MAX;
    wire bad_spl = (p_spl != SPL_NO_CTE) && ((p_spl < SPL_MIN) || (p_spl > SPL_MAX));
    // parameter total must match the antenna count it announces
    wire bad_len = (plen_r < TX_V4_FIXED_LEN) || (plen_r != TX_V4_FIXED_LEN + p_spl);
    wire reserved = bad_chan || bad_pay || bad_phy || bad_ctel || bad_ctyp || bad_spl;
    // no tone extension hardware, so a legal nonzero length is still refused
    wire [7:0] tx_status = (rx_test_run || run_r) ? ST_DISALLOWED :
                           (reserved || bad_len) ? ST_INVALID :
                           (p_ctel != CTE_NONE) ? ST_UNSUPPORTED : ST_OK;
    wire [7:0] exec_status = is_tx ? tx_status : is_end ? ST_OK : ST_UNKNOWN;

    // nearest supported power, with the two special codes
    wire signed [7:0] pwr_s = pwr_r;
    wire [7:0] pwr_sel = (pwr_r == PWR_CODE_MIN) ? PWR_SUPP_MIN :
                         (pwr_r == PWR_CODE_MAX) ? PWR_SUPP_MAX :
                         (pwr_s < $signed(PWR_SUPP_MIN)) ? PWR_SUPP_MIN :
                         (pwr_s > $signed(PWR_SUPP_MAX)) ? PWR_SUPP_MAX : pwr_r;

    // event byte by position
    wire [7:0] evt_len = end_op_r ? EVT_LEN_END : EVT_LEN_STATUS;
    wire evt_last = (eidx_r == evt_len + 8'h02);
    wire [7:0] eidx_nxt = eidx_r + 8'h01;
    wire [7:0] evt_byte = (eidx_nxt == 8'h01) ? EVT_CMD_COMPLETE :
                          (eidx_nxt == 8'h02) ? evt_len :
                          (eidx_nxt == 8'h03) ? CMD_CREDIT :
                          (eidx_nxt == 8'h04) ? op_r[7:0] :
                          (eidx_nxt == 8'h05) ? op_r[15:8] :
                          (eidx_nxt == 8'h06) ? status_r :
                          (eidx_nxt == 8'h07) ? end_cnt_r[7:0] : end_cnt_r[15:8];

    // command parser and event sender
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            cmd_ready_r <= 1'b1;
            evt_valid_r <= 1'b0;
            evt_data_r <= PAT_00;
            eidx_r <= 8'h00;
            pidx_r <= 8'h00;
            plen_r <= 8'h00;
            op_r <= RESET_COUNT;
            status_r <= ST_OK;
            pwr_r <= PAT_00;
            end_op_r <= 1'b0;
            end_cnt_r <= RESET_COUNT;
        end else if (ce) begin
            unique case (state_r)
                S_IDLE: if (take && link.cmd_data == H4_CMD) state_r <= S_OPL;
                S_OPL: if (take) begin
                    op_r[7:0] <= link.cmd_data;
                    state_r <= S_OPH;
                end
                S_OPH: if (take) begin
                    op_r[15:8] <= link.cmd_data;
                    state_r <= S_PLEN;
                end
                S_PLEN: if (take) begin
                    plen_r <= link.cmd_data;
                    pidx_r <= 8'h00;
                    state_r <= (link.cmd_data == 8'h00) ? S_EXEC : S_PARAM;
                    cmd_ready_r <= (link.cmd_data != 8'h00);
                end
                S_PARAM: if (take) begin
                    pidx_r <= pidx_r + 8'h01;
                    pwr_r <= link.cmd_data;
                    if (last_param) begin
                        state_r <= S_EXEC;
                        cmd_ready_r <= 1'b0;
                    end
                end
                S_EXEC: begin
                    status_r <= exec_status;
                    end_op_r <= is_end;
                    end_cnt_r <= pkt_cnt_r;
                    evt_data_r <= H4_EVT;
                    evt_valid_r <= 1'b1;
                    eidx_r <= 8'h00;
                    state_r <= S_EVT;
                end
                S_EVT: if (give) begin
                    if (evt_last) begin
                        evt_valid_r <= 1'b0;
                        cmd_ready_r <= 1'b1;
                        state_r <= S_IDLE;
                    end else begin
                        eidx_r <= eidx_nxt;
                        evt_data_r <= evt_byte;
                    end
                end
            endcase
        end
    end

    // parameter store, addressed by position; first eight bytes kept, antenna ids past the first only counted
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) param_r[i] <= PAT_00;
        end else if (ce && state_r == S_PARAM && take && pidx_r < TX_V4_FIXED_LEN) begin
            param_r[pidx_r[2:0]] <= link.cmd_data;
        end
    end

    // test control and packet generator
    wire start = ce && state_r == S_EXEC && is_tx && exec_status == ST_OK;
    wire stop = ce && state_r == S_EXEC && is_end;
    wire ival_done = (ival_r == 32'd0);
    wire [7:0] pat = pat_byte(pay_r);
    wire gen_bit = (pay_r == PAY_PRBS9) ? prbs9_r[0] :
                   (pay_r == PAY_PRBS15) ? prbs15_r[0] : pat[3'd7 - phase_r];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_r <= 1'b0;
            rx_end_r <= 1'b0;
            chan_r <= 8'h00;
            phy_r <= PHY_1M;
            power_r <= PAT_00;
            len_r <= 8'h00;
            pay_r <= PAY_PRBS9;
            ival_r <= 32'd0;
            pkt_cnt_r <= RESET_COUNT;
            strobe_r <= 1'b0;
            bits_r <= RESET_COUNT;
            bit_r <= 1'b0;
            bit_valid_r <= 1'b0;
            phase_r <= 3'd0;
            prbs9_r <= PRBS9_SEED;
            prbs15_r <= PRBS15_SEED;
        end else if (ce) begin
            rx_end_r <= stop && rx_test_run;
            strobe_r <= 1'b0;
            bit_valid_r <= 1'b0;
            if (start) begin
                run_r <= 1'b1;
                chan_r <= p_chan;
                phy_r <= p_phy;
                power_r <= pwr_sel;
                len_r <= param_r[IDX_LEN[2:0]];
                pay_r <= p_pay;
                pkt_cnt_r <= RESET_COUNT;
                ival_r <= 32'd0;
                bits_r <= RESET_COUNT;
            end else if (stop) begin
                run_r <= 1'b0;
                bits_r <= RESET_COUNT;
            end else if (run_r) begin
                // interval outlasts the longest payload, so packets never overlap
                ival_r <= ival_done ? 32'(PKT_INTERVAL - 1) : ival_r - 32'd1;
                if (ival_done) begin
                    strobe_r <= 1'b1;
                    pkt_cnt_r <= pkt_cnt_r + 16'h0001;
                    bits_r <= {5'd0, len_r, 3'd0};
                    phase_r <= 3'd0;
                    prbs9_r <= PRBS9_SEED;
                    prbs15_r <= PRBS15_SEED;
                end else if (bits_r != RESET_COUNT) begin
                    bit_valid_r <= 1'b1;
                    bit_r <= gen_bit;
                    bits_r <= bits_r - 16'h0001;
                    phase_r <= phase_r + 3'd1;
                    prbs9_r <= {prbs9_r[0] ^ prbs9_r[4], prbs9_r[8:1]};
                    prbs15_r <= {prbs15_r[0] ^ prbs15_r[1], prbs15_r[14:1]};
                end
            end
        end
    end
endmodule : lttv4_dev

// ===== rtl/lttv4_host.sv
// host end: frames test start and test end commands, collects the answer.
// assumes the controller end on the same clock; one command in flight.
module lttv4_host
    import lttv4_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // controller link
    lttv4_if.host link,
    // user requests
    input wire logic req_tx,
    input wire logic req_end,
    input wire logic [7:0] chan,
    input wire logic [7:0] data_len,
    input wire logic [7:0] payload,
    input wire logic [7:0] phy,
    input wire logic [7:0] power,
    // user answers
    output logic busy,
    output logic done,
    output logic [7:0] status,
    output logic [15:0] num_packets,
    output logic [7:0] credit
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b001, H_SEND = 3'b010, H_WAIT = 3'b100
    } lttv4_hstate_t;

    lttv4_hstate_t state_r;
    logic cmd_valid_r, evt_ready_r, end_r, busy_r, done_r;
    logic [7:0] cmd_data_r, cidx_r, eidx_r, elen_r, status_r, credit_r;
    logic [7:0] chan_r, len_r, pay_r, phy_r, pwr_r;
    logic [15:0] cnt_r;

    assign link.cmd_valid = cmd_valid_r;
    assign link.cmd_data = cmd_data_r;
    assign link.evt_ready = evt_ready_r;
    assign busy = busy_r;
    assign done = done_r;
    assign status = status_r;
    assign num_packets = cnt_r;
    assign credit = credit_r;

    // command byte by position; tone extension fields fixed at zero
    wire [7:0] cidx_nxt = cidx_r + 8'h01;
    wire [7:0] cmd_last = end_r ? 8'h03 : TX_V4_FIXED_LEN + 8'h04;
    wire [7:0] cmd_byte = (cidx_nxt == 8'h01) ? (end_r ? OP_TEST_END[7:0] : OP_TX_V4[7:0]) :
                          (cidx_nxt == 8'h02) ? (end_r ? OP_TEST_END[15:8] : OP_TX_V4[15:8]) :
                          (cidx_nxt == 8'h03) ? (end_r ? 8'h00 : TX_V4_FIXED_LEN + SPL_NO_CTE) :
                          (cidx_nxt == 8'h04) ? chan_r :
                          (cidx_nxt == 8'h05) ? len_r :
                          (cidx_nxt == 8'h06) ? pay_r :
                          (cidx_nxt == 8'h07) ? phy_r :
                          (cidx_nxt == 8'h08) ? CTE_NONE :
                          (cidx_nxt == 8'h09) ? CTE_NONE :
                          (cidx_nxt == 8'h0A) ? SPL_NO_CTE :
                          (cidx_nxt == 8'h0B) ? ANT_ID_DEFAULT : pwr_r;
    wire sent = ce && cmd_valid_r && link.cmd_ready;
    wire got = ce && evt_ready_r && link.evt_valid;
    wire evt_last = (eidx_r >= 8'h03) && (eidx_r == elen_r + 8'h02);
    // a new command waits for credit from the last event
    wire go = ce && state_r == H_IDLE && credit_r != 8'h00 && (req_tx || req_end);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= H_IDLE;
            cmd_valid_r <= 1'b0;
            cmd_data_r <= 8'h00;
            evt_ready_r <= 1'b0;
            end_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cidx_r <= 8'h00;
            eidx_r <= 8'h00;
            elen_r <= 8'h00;
            status_r <= ST_OK;
            credit_r <= CMD_CREDIT;
            cnt_r <= RESET_COUNT;
            {chan_r, len_r, pay_r, phy_r, pwr_r} <= 40'h0;
        end else if (ce) begin
            done_r <= 1'b0;
            unique case (state_r)
                H_IDLE: if (go) begin
                    // test end wins when both are asked together
                    end_r <= req_end;
                    {chan_r, len_r, pay_r, phy_r, pwr_r} <= {chan, data_len, payload, phy, power};
                    cmd_data_r <= H4_CMD;
                    cmd_valid_r <= 1'b1;
                    cidx_r <= 8'h00;
                    busy_r <= 1'b1;
                    state_r <= H_SEND;
                end
                H_SEND: if (sent) begin
                    if (cidx_r == cmd_last) begin
                        cmd_valid_r <= 1'b0;
                        evt_ready_r <= 1'b1;
                        eidx_r <= 8'h00;
                        state_r <= H_WAIT;
                    end else begin
                        cidx_r <= cidx_nxt;
                        cmd_data_r <= cmd_byte;
                    end
                end
                H_WAIT: if (got) begin
                    eidx_r <= eidx_r + 8'h01;
                    if (eidx_r == 8'h02) elen_r <= link.evt_data;
                    if (eidx_r == 8'h03) credit_r <= link.evt_data;
                    if (eidx_r == 8'h06) status_r <= link.evt_data;
                    if (eidx_r == 8'h07) cnt_r[7:0] <= link.evt_data;
                    if (eidx_r == 8'h08) cnt_r[15:8] <= link.evt_data;
                    if (evt_last) begin
                        evt_ready_r <= 1'b0;
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        state_r <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : lttv4_host

// ===== rtl/lttv4_if.sv
// byte streams between host and controller: commands in, events out.
// assumes both ends share one clock; valid/ready handshake on each stream.
interface lttv4_if;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic cmd_ready;
    logic evt_valid;
    logic [7:0] evt_data;
    logic evt_ready;
    modport dev(input cmd_valid, input cmd_data, output cmd_ready,
                output evt_valid, output evt_data, input evt_ready);
    modport host(output cmd_valid, output cmd_data, input cmd_ready,
                 input evt_valid, input evt_data, output evt_ready);
endinterface : lttv4_if

// ===== rtl/lttv4_pkg.sv
// constants shared by both ends of the transmitter test command link.
// assumes one 10 MHz clock and byte-wide command and event streams.
package lttv4_pkg;
    // packet framing
    localparam logic [7:0] H4_CMD = 8'h01;
    localparam logic [7:0] H4_EVT = 8'h04;
    localparam logic [7:0] EVT_CMD_COMPLETE = 8'h0E;
    localparam logic [5:0] OGF_LE = 6'h08;
    localparam logic [9:0] OCF_TX_V4 = 10'h07B;
    localparam logic [9:0] OCF_TEST_END = 10'h01F;
    localparam logic [15:0] OP_TX_V4 = {OGF_LE, OCF_TX_V4};
    localparam logic [15:0] OP_TEST_END = {OGF_LE, OCF_TEST_END};
    localparam logic [7:0] EVT_LEN_STATUS = 8'h04;
    localparam logic [7:0] EVT_LEN_END = 8'h06;
    localparam logic [7:0] CMD_CREDIT = 8'h01;
    // parameter field indices and limits
    localparam logic [7:0] IDX_CHAN = 8'h00;
    localparam logic [7:0] IDX_LEN = 8'h01;
    localparam logic [7:0] IDX_PAY = 8'h02;
    localparam logic [7:0] IDX_PHY = 8'h03;
    localparam logic [7:0] IDX_CTE_LEN = 8'h04;
    localparam logic [7:0] IDX_CTE_TYPE = 8'h05;
    localparam logic [7:0] IDX_SPL = 8'h06;
    localparam logic [7:0] TX_V4_FIXED_LEN = 8'h08;
    localparam logic [7:0] CHAN_MAX = 8'h27;
    localparam logic [7:0] PAYLOAD_MAX = 8'h07;
    localparam logic [7:0] PAY_PRBS9 = 8'h00;
    localparam logic [7:0] PAY_PRBS15 = 8'h03;
    localparam logic [7:0] PHY_1M = 8'h01;
    localparam logic [7:0] PHY_CODED_S2 = 8'h04;
    localparam logic [7:0] CTE_NONE = 8'h00;
    localparam logic [7:0] CTE_LEN_MIN = 8'h02;
    localparam logic [7:0] CTE_LEN_MAX = 8'h14;
    localparam logic [7:0] CTE_TYPE_MAX = 8'h02;
    localparam logic [7:0] SPL_NO_CTE = 8'h01;
    localparam logic [7:0] SPL_MIN = 8'h02;
    localparam logic [7:0] SPL_MAX = 8'h4B;
    localparam logic [7:0] ANT_ID_DEFAULT = 8'h00;
    localparam logic [7:0] PWR_CODE_MIN = 8'h7E;
    localparam logic [7:0] PWR_CODE_MAX = 8'h7F;
    localparam logic [7:0] PWR_SUPP_MIN = 8'hEC;
    localparam logic [7:0] PWR_SUPP_MAX = 8'h0A;
    // status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_UNKNOWN = 8'h01;
    localparam logic [7:0] ST_DISALLOWED = 8'h0C;
    localparam logic [7:0] ST_UNSUPPORTED = 8'h11;
    localparam logic [7:0] ST_INVALID = 8'h12;
    // payload patterns, first transmitted bit in bit 7
    localparam logic [7:0] PAT_F0 = 8'hF0;
    localparam logic [7:0] PAT_AA = 8'hAA;
    localparam logic [7:0] PAT_FF = 8'hFF;
    localparam logic [7:0] PAT_00 = 8'h00;
    localparam logic [7:0] PAT_0F = 8'h0F;
    localparam logic [7:0] PAT_55 = 8'h55;
    localparam logic [8:0] PRBS9_SEED = 9'h1FF;
    localparam logic [14:0] PRBS15_SEED = 15'h7FFF;
    // timing
    localparam int CLK_MHZ = 10;
    localparam int PKT_INTERVAL_US = 625;
    localparam int PKT_INTERVAL_CYC = PKT_INTERVAL_US * CLK_MHZ;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
endpackage : lttv4_pkg

// ===== sim/lttv4_checker.sv
// assertions on the command and event byte streams between host and controller.
// assumes one clock; takes the interface signals as plain inputs.
module lttv4_checker (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // command and event streams
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ready,
    input wire logic evt_valid,
    input wire logic [7:0] evt_data,
    input wire logic evt_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire cmd_take = ce & cmd_valid & cmd_ready;
    wire evt_take = ce & evt_valid & evt_ready;
    logic [3:0] cmd_idx_r;
    logic [3:0] evt_idx_r;
    // counters saturate so a runaway stream cannot wrap back onto byte 0
    wire [3:0] cmd_idx_nxt = evt_valid ? 4'h0 : (cmd_take && cmd_idx_r != 4'hF) ? cmd_idx_r + 4'h1 : cmd_idx_r;
    wire [3:0] evt_idx_nxt = cmd_take ? 4'h0 : (evt_take && evt_idx_r != 4'hF) ? evt_idx_r + 4'h1 : evt_idx_r;
    always_ff @(posedge clk) begin
        cmd_idx_r <= resetn ? cmd_idx_nxt : 4'h0;
        evt_idx_r <= resetn ? evt_idx_nxt : 4'h0;
    end
    a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("command byte changed before it was taken");
    a_evt_hold: assert property (evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
        else $error("event byte changed before it was taken");
    a_cmd_type: assert property (cmd_take && cmd_idx_r == 4'h0 |-> cmd_data == 8'h01)
        else $error("command packet not opened by type byte");
    a_op_high: assert property (cmd_take && cmd_idx_r == 4'h2 |-> cmd_data == 8'h20)
        else $error("opcode high byte wrong");
    a_evt_first: assert property ($rose(evt_valid) |-> evt_data == 8'h04)
        else $error("event packet not opened by type byte");
    a_evt_code: assert property (evt_take && evt_idx_r == 4'h1 |-> evt_data == 8'h0E)
        else $error("event code wrong");
    a_credit_oct: assert property (evt_take && evt_idx_r == 4'h3 |-> evt_data == 8'h01)
        else $error("command credit wrong");
    a_evt_op_high: assert property (evt_take && evt_idx_r == 4'h5 |-> evt_data == 8'h20)
        else $error("echoed opcode high byte wrong");
    a_ready_blocked: assert property (evt_valid |-> !cmd_ready)
        else $error("command stream open while answer pending");
    a_answer_time: assert property ($fell(cmd_ready) |-> ##[1:3] evt_valid)
        else $error("answer late after last command byte");
endmodule : lttv4_checker

// ===== sim/lttv4_tb_top.sv
// bench joining host and controller ends; drives the host user side.
// assumes one 10 MHz clock; inputs change at the falling edge.
module lttv4_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lttv4_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, rx_run = 1'b0, req_tx = 1'b0, req_end = 1'b0;
    logic [7:0] chan = 8'h00, len = 8'h00, pay = 8'h00, phy = 8'h01, pwr = 8'h00;
    logic rx_end_req, tx_run, tx_pkt_start, tx_bit, tx_bit_valid, busy, done;
    logic [7:0] tx_chan, tx_phy, tx_power, status, credit;
    logic [15:0] num_packets, pkt_cnt = 16'h0000;
    logic [7:0] evq[$];
    int error_cnt = 0, num_checks = 0, rx_ends = 0;
    always #50 clk = ~clk;
    lttv4_if i_lttv4_if();
    // short interval; must exceed 8*len
    lttv4_dev #(.PKT_INTERVAL(40)) i_lttv4_dev(.clk(clk), .resetn(resetn), .ce(ce), .link(i_lttv4_if.dev),
        .rx_test_run(rx_run), .rx_end_req(rx_end_req), .tx_run(tx_run), .tx_chan(tx_chan), .tx_phy(tx_phy),
        .tx_power(tx_power), .tx_pkt_start(tx_pkt_start), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
    lttv4_host i_lttv4_host(.clk(clk), .resetn(resetn), .ce(ce), .link(i_lttv4_if.host), .req_tx(req_tx),
        .req_end(req_end), .chan(chan), .data_len(len), .payload(pay), .phy(phy), .power(pwr), .busy(busy),
        .done(done), .status(status), .num_packets(num_packets), .credit(credit));
    lttv4_checker i_lttv4_checker(.clk(clk), .resetn(resetn), .ce(ce), .cmd_valid(i_lttv4_if.cmd_valid),
        .cmd_data(i_lttv4_if.cmd_data), .cmd_ready(i_lttv4_if.cmd_ready), .evt_valid(i_lttv4_if.evt_valid),
        .evt_data(i_lttv4_if.evt_data), .evt_ready(i_lttv4_if.evt_ready));
    always @(posedge clk) begin
        if (ce && i_lttv4_if.evt_valid && i_lttv4_if.evt_ready)
            evq.push_back(i_lttv4_if.evt_data);
        if (ce && tx_pkt_start)
            pkt_cnt <= pkt_cnt + 16'h0001;
        if (rx_end_req)
            rx_ends <= rx_ends + 1;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic do_req(input logic e, input logic [7:0] c, l, p, h, w, st);
        logic [7:0] exp[$];
        int n;
        evq = {};
        n = 0;
        @(negedge clk);
        {req_end, req_tx, chan, len, pay, phy, pwr} = {e, ~e, c, l, p, h, w};
        @(negedge clk);
        {req_end, req_tx} = 2'b00;
        chk("busy", 16'h0001, {15'h0, busy});
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        exp = {8'h04, 8'h0E, e ? 8'h06 : 8'h04, 8'h01, e ? 8'h1F : 8'h7B, 8'h20, st};
        if (e) exp = {exp, pkt_cnt[7:0], pkt_cnt[15:8]};
        if (e) chk("count", pkt_cnt, num_packets);
        chk("done seen", 16'h0001, {15'h0, done});
        chk("status", {8'h00, st}, {8'h00, status});
        chk("credit", 16'h0001, {8'h00, credit});
        chk("event size", 16'(exp.size()), 16'(evq.size()));
        foreach (exp[i]) chk("event byte", {8'h00, exp[i]}, {8'h00, evq[i]});
    endtask : do_req
    task automatic wait_pkt();
        int n;
        n = 0;
        while (tx_pkt_start !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_pkt
    task automatic get_bits(input logic [15:0] exp);
        logic [15:0] b;
        int n;
        b = 16'h0000;
        n = 0;
        wait_pkt();
        repeat (40) begin
            @(negedge clk);
            if (tx_bit_valid === 1'b1 && n < 16) begin
                b = {b[14:0], tx_bit};
                n++;
            end
        end
        chk("payload bits", exp, b);
    endtask : get_bits
    task automatic end_test();
        wait_pkt();
        do_req(1'b1, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
        chk("tx stopped", 16'h0000, {15'h0, tx_run});
    endtask : end_test
    task automatic t_start();
        pkt_cnt = 16'h0000;
        do_req(1'b0, 8'h27, 8'h02, 8'h01, 8'h02, 8'h7F, 8'h00);
        chk("tx run", 16'h0001, {15'h0, tx_run});
        chk("channel", 16'h0027, {8'h00, tx_chan});
        chk("phy", 16'h0002, {8'h00, tx_phy});
        chk("power max", 16'h000A, {8'h00, tx_power});
        get_bits(16'hF0F0);
        $display("t_start finished");
    endtask : t_start
    task automatic t_busy();
        // ce low freezes the run; a second start is refused
        logic [15:0] k;
        k = pkt_cnt;
        ce = 1'b0;
        repeat (60) @(negedge clk);
        chk("frozen", k, pkt_cnt);
        ce = 1'b1;
        do_req(1'b0, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00, 8'h0C);
        chk("still running", 16'h0001, {15'h0, tx_run});
        $display("t_busy finished");
    endtask : t_busy
    task automatic t_end();
        int n;
        n = 0;
        end_test();
        repeat (100) begin
            @(negedge clk);
            n += int'(tx_pkt_start === 1'b1);
        end
        chk("packets after end", 16'h0000, 16'(n));
        $display("t_end finished");
    endtask : t_end
    task automatic t_rx();
        rx_run = 1'b1;
        do_req(1'b0, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h0C);
        chk("no start in rx", 16'h0000, {15'h0, tx_run});
        do_req(1'b1, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
        chk("rx end", 16'h0001, 16'(rx_ends));
        rx_run = 1'b0;
        $display("t_rx finished");
    endtask : t_rx
    task automatic t_bad();
        // channel, payload and PHY fields each just past a legal limit
        logic [23:0] tbl[4] = '{24'h280001, 24'h000801, 24'h000000, 24'h000005};
        foreach (tbl[i]) begin
            do_req(1'b0, tbl[i][23:16], 8'h01, tbl[i][15:8], tbl[i][7:0], 8'h00, 8'h12);
            chk("no start", 16'h0000, {15'h0, tx_run});
        end
        $display("t_bad finished");
    endtask : t_bad
    task automatic t_prbs();
        pkt_cnt = 16'h0000;
        do_req(1'b0, 8'h05, 8'h02, 8'h00, 8'h04, 8'h7E, 8'h00);
        chk("power min", 16'h00EC, {8'h00, tx_power});
        chk("phy coded", 16'h0004, {8'h00, tx_phy});
        get_bits(16'hFF83);
        end_test();
        $display("t_prbs finished");
    endtask : t_prbs
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        t_start();
        t_busy();
        t_end();
        t_rx();
        t_bad();
        t_prbs();
        wrap_up();
    end
    initial begin
        #(100 * 4000);
        error_cnt++;
        wrap_up();
    end
endmodule : lttv4_tb_top
